//--- logic/chl_pkg.sv
// Constants, types and carriers for the home, clear and insert-line sequencer.
// What this block does
// - Seven steps advance in order on phase one.
// - Home leaves cursor at column zero, row zero.
// - Host home clears counters without running steps.
// - Keyboard home clears both counters step four.
// - Host strobes OR with sequencer clears.
// - Bright-only clear spares low-intensity locations.
// - Total clear skips the intensity test.
// - Clears accepted alike from keyboard or host.
// - Clear or insert step one suspends refresh until routine ends.
// - Clear step two homes both counters.
// - Clear step three writes blank when allowed.
// - Clear step four advances column, reads, carries.
// - Clear loops to step three until home.
// - Insert line rolls rows down, blanks cursor row.
// - Insert step one zeroes column, stores row.
// - Insert step three leaves counters at full count.
// - Rows above 26 still stepped through.
// - Insert step four moves up, reads on phase six.
// - Insert step five moves down, copies data.
// - Copied data written, blank on start line.
// - Insert ends at step six on start, column zero.
// - Insert step seven decrements column, borrow steps row.
// - Counters step on phase three count pulse.
`default_nettype none

package chl_pkg;

    localparam int             COL_W      = 7;
    localparam int             ROW_W      = 5;
    localparam int             CHAR_W     = 8;
    localparam int             PHASE_W    = 3;
    localparam int             BRIGHT_BIT = 7;
    localparam logic [6:0]     COL_ZERO   = 7'h00;
    localparam logic [6:0]     COL_LAST   = 7'h49;
    localparam logic [6:0]     COL_FULL   = 7'h7F;
    localparam logic [4:0]     ROW_ZERO   = 5'h00;
    localparam logic [4:0]     ROW_LAST   = 5'h1A;
    localparam logic [4:0]     ROW_FULL   = 5'h1F;
    localparam logic [2:0]     PH1        = 3'h0;
    localparam logic [2:0]     PH2        = 3'h1;
    localparam logic [2:0]     PH3        = 3'h2;
    localparam logic [2:0]     PH5        = 3'h4;
    localparam logic [2:0]     PH6        = 3'h5;
    localparam logic [7:0]     BLANK_CHAR = 8'hA0;
    localparam logic [7:0]     DATA_RESET = 8'h00;

    typedef enum logic [3:0] {
        CHL_IDLE, CHL_S1, CHL_S2, CHL_S3, CHL_S4, CHL_S5, CHL_S6, CHL_S7
    } chl_step_t;

    typedef enum logic [2:0] {
        CHL_FN_NONE, CHL_FN_HOME, CHL_FN_CLR_BRIGHT, CHL_FN_CLR_TOTAL, CHL_FN_INSERT
    } chl_func_t;

    typedef struct packed {
        logic bright_only_clear;
        logic total_clear;
        logic insert_line;
    } chl_req_t;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] data;
    } chl_mem_cmd_t;

endpackage : chl_pkg

`default_nettype wire

//--- logic/chl_cursor_counter.sv
// Up/down cursor counter with clear, carry and borrow.
`timescale 1ns/100ps
`default_nettype none

module chl_cursor_counter #(
    parameter int               WIDTH = 7,
    parameter logic [WIDTH-1:0] LAST  = '1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             count_pulse,
    input  wire logic             up,
    input  wire logic             down,
    input  wire logic             wrap,
    output logic [WIDTH-1:0]      value,
    output logic                  carry,
    output logic                  borrow
);

    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;

    if (WIDTH < 2) begin : g_chk
        $error("chl_cursor_counter: WIDTH too small");
    end

    assign carry  = up && (value_r == LAST);
    assign borrow = down && (value_r == '0);
    assign value  = value_r;

    always_comb begin
        value_nxt = value_r;
        if (clear) begin
            value_nxt = '0;
        end else if (count_pulse && up) begin
            value_nxt = (wrap && carry) ? '0 : value_r + 1'b1;
        end else if (count_pulse && down) begin
            value_nxt = value_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            value_r <= '0;
        end else begin
            value_r <= value_nxt;
        end
    end

endmodule : chl_cursor_counter

`default_nettype wire

//--- logic/chl_sequencer.sv
// Step sequencer for cursor home, screen clear and insert line.
`timescale 1ns/100ps
`default_nettype none

module chl_sequencer (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire logic                  kb_home,
    input  wire chl_pkg::chl_req_t     kb_req,
    input  wire chl_pkg::chl_req_t     host_req,
    input  wire logic                  host_column_zero_strobe,
    input  wire logic                  host_row_zero_strobe,
    input  wire logic [7:0]            mem_read_data,
    output chl_pkg::chl_mem_cmd_t      mem_cmd,
    output logic                       refresh_skip,
    output logic                       busy,
    output logic                       cursor_count_pulse,
    output logic [6:0]                 cursor_column_counter,
    output logic [4:0]                 cursor_row_counter
);

    logic [2:0]            phase_r;
    logic [2:0]            phase_nxt;
    chl_pkg::chl_step_t    step_r;
    chl_pkg::chl_step_t    step_nxt;
    chl_pkg::chl_func_t    func_r;
    chl_pkg::chl_func_t    func_nxt;
    logic [4:0]            start_row_r;
    logic [4:0]            start_row_nxt;
    logic [4:0]            line_repeat_r;
    logic [4:0]            line_repeat_nxt;
    logic                  refresh_skip_r;
    logic                  refresh_skip_nxt;
    chl_pkg::chl_mem_cmd_t mem_cmd_r;
    chl_pkg::chl_mem_cmd_t mem_cmd_nxt;

    logic ph1, ph2, ph3, ph5, ph6;
    logic fn_home, fn_clear, fn_total, fn_insert;
    logic bright_only_clear, total_clear, insert_line;
    logic at_home, start_coinc, bright_intensity_flag;
    logic col_clear, row_clear, col_up, col_down, row_up, row_down;
    logic col_carry, column_underflow, row_carry_unused, row_borrow_unused;
    logic [6:0] col;
    logic [4:0] row;

    assign ph1 = (phase_r == chl_pkg::PH1);
    assign ph2 = (phase_r == chl_pkg::PH2);
    assign ph3 = (phase_r == chl_pkg::PH3);
    assign ph5 = (phase_r == chl_pkg::PH5);
    assign ph6 = (phase_r == chl_pkg::PH6);

    assign fn_home   = (func_r == chl_pkg::CHL_FN_HOME);
    assign fn_total  = (func_r == chl_pkg::CHL_FN_CLR_TOTAL);
    assign fn_clear  = fn_total || (func_r == chl_pkg::CHL_FN_CLR_BRIGHT);
    assign fn_insert = (func_r == chl_pkg::CHL_FN_INSERT);

    // Either source of a request starts the same routine.
    assign bright_only_clear = kb_req.bright_only_clear || host_req.bright_only_clear;
    assign total_clear       = kb_req.total_clear || host_req.total_clear;
    assign insert_line       = kb_req.insert_line || host_req.insert_line;

    assign at_home               = (col == chl_pkg::COL_ZERO) && (row == chl_pkg::ROW_ZERO);
    assign start_coinc           = (line_repeat_r == start_row_r);
    assign bright_intensity_flag = mem_read_data[chl_pkg::BRIGHT_BIT];

    // Phase counter: six timing phases per step, free running.
    always_comb begin
        phase_nxt = ph6 ? chl_pkg::PH1 : phase_r + 3'h1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= chl_pkg::PH1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Requests are taken only while idle; the step runs from the next first phase.
    always_comb begin
        step_nxt = step_r;
        func_nxt = func_r;
        if (step_r == chl_pkg::CHL_IDLE && func_r == chl_pkg::CHL_FN_NONE) begin
            if (insert_line) begin
                func_nxt = chl_pkg::CHL_FN_INSERT;
            end else if (total_clear) begin
                func_nxt = chl_pkg::CHL_FN_CLR_TOTAL;
            end else if (bright_only_clear) begin
                func_nxt = chl_pkg::CHL_FN_CLR_BRIGHT;
            end else if (kb_home) begin
                func_nxt = chl_pkg::CHL_FN_HOME;
            end
        end
        if (ph6) begin
            case (step_r)
                chl_pkg::CHL_IDLE: begin
                    if (func_r != chl_pkg::CHL_FN_NONE) begin
                        step_nxt = chl_pkg::CHL_S1;
                    end
                end
                chl_pkg::CHL_S1: step_nxt = chl_pkg::CHL_S2;
                chl_pkg::CHL_S2: step_nxt = chl_pkg::CHL_S3;
                chl_pkg::CHL_S3: step_nxt = chl_pkg::CHL_S4;
                chl_pkg::CHL_S4: step_nxt = chl_pkg::CHL_S5;
                chl_pkg::CHL_S5: begin
                    step_nxt = (fn_clear && !at_home) ? chl_pkg::CHL_S3 : chl_pkg::CHL_S6;
                end
                chl_pkg::CHL_S6: begin
                    if (fn_insert && start_coinc && col == chl_pkg::COL_ZERO) begin
                        step_nxt = chl_pkg::CHL_IDLE;
                        func_nxt = chl_pkg::CHL_FN_NONE;
                    end else begin
                        step_nxt = chl_pkg::CHL_S7;
                    end
                end
                chl_pkg::CHL_S7: begin
                    if (fn_insert) begin
                        step_nxt = chl_pkg::CHL_S4;
                    end else begin
                        step_nxt = chl_pkg::CHL_IDLE;
                        func_nxt = chl_pkg::CHL_FN_NONE;
                    end
                end
                default: begin
                    step_nxt = chl_pkg::CHL_IDLE;
                    func_nxt = chl_pkg::CHL_FN_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            step_r <= chl_pkg::CHL_IDLE;
            func_r <= chl_pkg::CHL_FN_NONE;
        end else begin
            step_r <= step_nxt;
            func_r <= func_nxt;
        end
    end

    // Counter controls. Host strobes act at any time, even mid-routine.
    always_comb begin
        col_clear = host_column_zero_strobe
                 || (fn_home && step_r == chl_pkg::CHL_S4 && ph1)
                 || (fn_clear && step_r == chl_pkg::CHL_S2 && ph2)
                 || (fn_insert && step_r == chl_pkg::CHL_S1 && ph2);
        row_clear = host_row_zero_strobe
                 || (fn_home && step_r == chl_pkg::CHL_S4 && ph1)
                 || (fn_clear && step_r == chl_pkg::CHL_S2 && ph2)
                 || (fn_insert && step_r == chl_pkg::CHL_S3 && ph2);
        col_up   = fn_clear && step_r == chl_pkg::CHL_S4;
        col_down = fn_insert && (step_r == chl_pkg::CHL_S3 || step_r == chl_pkg::CHL_S7);
        row_up   = (fn_insert && step_r == chl_pkg::CHL_S5) || col_carry;
        row_down = (fn_insert && step_r == chl_pkg::CHL_S4) || column_underflow;
        cursor_count_pulse = ph3 && (col_up || col_down || row_up || row_down);
    end

    chl_cursor_counter #(
        .WIDTH (chl_pkg::COL_W),
        .LAST  (chl_pkg::COL_LAST)
    ) u_column (
        .clk         (clk),
        .reset       (reset),
        .clear       (col_clear),
        .count_pulse (cursor_count_pulse),
        .up          (col_up),
        .down        (col_down),
        .wrap        (fn_clear),
        .value       (col),
        .carry       (col_carry),
        .borrow      (column_underflow)
    );

    // Rows above the last still count so the insert loop can walk down to it.
    chl_cursor_counter #(
        .WIDTH (chl_pkg::ROW_W),
        .LAST  (chl_pkg::ROW_LAST)
    ) u_row (
        .clk         (clk),
        .reset       (reset),
        .clear       (row_clear),
        .count_pulse (cursor_count_pulse),
        .up          (row_up),
        .down        (row_down),
        .wrap        (fn_clear),
        .value       (row),
        .carry       (row_carry_unused),
        .borrow      (row_borrow_unused)
    );

    assign cursor_column_counter = col;
    assign cursor_row_counter    = row;

    // Line repeat counter tracks the row being rewritten; coincidence marks the start line.
    always_comb begin
        start_row_nxt   = start_row_r;
        line_repeat_nxt = line_repeat_r;
        if (fn_insert && ph2) begin
            if (step_r == chl_pkg::CHL_S1) begin
                start_row_nxt = row;
            end else if (step_r == chl_pkg::CHL_S3) begin
                line_repeat_nxt = chl_pkg::ROW_FULL;
            end else if (step_r == chl_pkg::CHL_S7 && col == chl_pkg::COL_ZERO) begin
                line_repeat_nxt = line_repeat_r - 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            start_row_r   <= chl_pkg::ROW_ZERO;
            line_repeat_r <= chl_pkg::ROW_ZERO;
        end else begin
            start_row_r   <= start_row_nxt;
            line_repeat_r <= line_repeat_nxt;
        end
    end

    // Refresh is suspended from step one to the end of a clear or insert.
    always_comb begin
        refresh_skip_nxt = refresh_skip_r;
        if (step_r == chl_pkg::CHL_S1 && ph1 && (fn_clear || fn_insert)) begin
            refresh_skip_nxt = 1'b1;
        end else if (step_r != chl_pkg::CHL_IDLE && step_nxt == chl_pkg::CHL_IDLE) begin
            refresh_skip_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            refresh_skip_r <= 1'b0;
        end else begin
            refresh_skip_r <= refresh_skip_nxt;
        end
    end

    // Memory commands are decided in phase five and stand during phase six.
    always_comb begin
        mem_cmd_nxt       = mem_cmd_r;
        mem_cmd_nxt.read  = 1'b0;
        mem_cmd_nxt.write = 1'b0;
        if (ph5 && fn_clear) begin
            if (step_r == chl_pkg::CHL_S2 || step_r == chl_pkg::CHL_S4) begin
                mem_cmd_nxt.read = 1'b1;
            end else if (step_r == chl_pkg::CHL_S3 && (fn_total || bright_intensity_flag)) begin
                mem_cmd_nxt.write = 1'b1;
                mem_cmd_nxt.data  = chl_pkg::BLANK_CHAR;
            end
        end else if (ph5 && fn_insert) begin
            if (step_r == chl_pkg::CHL_S4) begin
                mem_cmd_nxt.read = 1'b1;
            end else if (step_r == chl_pkg::CHL_S5) begin
                mem_cmd_nxt.write = 1'b1;
                mem_cmd_nxt.data  = start_coinc ? chl_pkg::BLANK_CHAR : mem_read_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mem_cmd_r <= '{read: 1'b0, write: 1'b0, data: chl_pkg::DATA_RESET};
        end else begin
            mem_cmd_r <= mem_cmd_nxt;
        end
    end

    assign mem_cmd      = mem_cmd_r;
    assign refresh_skip = refresh_skip_r;
    assign busy         = (step_r != chl_pkg::CHL_IDLE) || (func_r != chl_pkg::CHL_FN_NONE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_step_on_phase_one;
        (step_r != $past(step_r)) |-> ph1;
    endproperty
    a_step_on_phase_one: assert property (p_step_on_phase_one) else $error("step changed off phase one");

    property p_kb_home;
        (fn_home && step_r == chl_pkg::CHL_S4 && ph1 && !col_up) |=> (col == chl_pkg::COL_ZERO && row == chl_pkg::ROW_ZERO);
    endproperty
    a_kb_home: assert property (p_kb_home) else $error("keyboard home missed");

    property p_host_home;
        (host_column_zero_strobe && host_row_zero_strobe) |=> at_home;
    endproperty
    a_host_home: assert property (p_host_home) else $error("host home missed");

    property p_protected_kept;
        (mem_cmd_r.write && func_r == chl_pkg::CHL_FN_CLR_BRIGHT) |-> $past(bright_intensity_flag);
    endproperty
    a_protected_kept: assert property (p_protected_kept) else $error("protected location written");

    property p_total_writes;
        (fn_total && step_r == chl_pkg::CHL_S3 && ph5) |=> (mem_cmd_r.write && mem_cmd_r.data == chl_pkg::BLANK_CHAR);
    endproperty
    a_total_writes: assert property (p_total_writes) else $error("total clear skipped a write");

    property p_refresh_held;
        ((fn_clear || fn_insert) && step_r != chl_pkg::CHL_IDLE && step_r != chl_pkg::CHL_S1) |-> refresh_skip;
    endproperty
    a_refresh_held: assert property (p_refresh_held) else $error("refresh not suspended");

    sequence s_clear_s5_end;
        fn_clear && step_r == chl_pkg::CHL_S5 && ph6 && !at_home;
    endsequence
    property p_clear_loop;
        s_clear_s5_end |=> step_r == chl_pkg::CHL_S3 ##6 step_r == chl_pkg::CHL_S4;
    endproperty
    a_clear_loop: assert property (p_clear_loop) else $error("clear loop broken");

    property p_col_wrap;
        (col_up && cursor_count_pulse && col == chl_pkg::COL_LAST) |=> (col == chl_pkg::COL_ZERO && row != $past(row));
    endproperty
    a_col_wrap: assert property (p_col_wrap) else $error("column carry lost");

    property p_insert_full;
        (fn_insert && step_r == chl_pkg::CHL_S3 && ph3) |=> (col == chl_pkg::COL_FULL && row == chl_pkg::ROW_FULL);
    endproperty
    a_insert_full: assert property (p_insert_full) else $error("insert counters not full");

    property p_start_blank;
        (fn_insert && step_r == chl_pkg::CHL_S5 && ph5 && start_coinc) |=> (mem_cmd_r.write && mem_cmd_r.data == chl_pkg::BLANK_CHAR);
    endproperty
    a_start_blank: assert property (p_start_blank) else $error("start line not blanked");

    property p_insert_end;
        (fn_insert && step_r == chl_pkg::CHL_S6 && ph6 && start_coinc && col == chl_pkg::COL_ZERO) |=> !busy;
    endproperty
    a_insert_end: assert property (p_insert_end) else $error("insert did not end");

endmodule : chl_sequencer

`default_nettype wire

//--- tb/chl_mem_model.sv
// Character memory model with its read data register.
`timescale 1ns/100ps
`default_nettype none

module chl_mem_model (
    input  wire logic                  clk,
    input  wire chl_pkg::chl_mem_cmd_t mem_cmd,
    input  wire logic [6:0]            col,
    input  wire logic [4:0]            row,
    output logic [7:0]                 read_data
);
    logic [7:0] cells [0:31][0:127];

    initial read_data = 8'h00;

    // The read register holds its value until the next read, so the bright bit stays valid.
    always @(posedge clk) begin
        if (mem_cmd.read === 1'b1) begin
            read_data <= cells[row][col];
        end
        if (mem_cmd.write === 1'b1) begin
            cells[row][col] <= mem_cmd.data;
        end
    end
endmodule : chl_mem_model
`default_nettype wire

//--- tb/tb_cursor_home_clear_insert_line_sequencer.sv
// Self-checking bench for the home, clear and insert-line sequencer.
`timescale 1ns/100ps
`default_nettype none

module tb_cursor_home_clear_insert_line_sequencer;
    logic                  clk;
    logic                  reset;
    logic                  kb_home;
    chl_pkg::chl_req_t     kb_req;
    chl_pkg::chl_req_t     host_req;
    logic                  hcs;
    logic                  hrs;
    logic [7:0]            rd;
    chl_pkg::chl_mem_cmd_t mem_cmd;
    logic                  refresh_skip;
    logic                  busy;
    logic                  ccp;
    logic [6:0]            col;
    logic [4:0]            row;
    logic [7:0]            shadow [0:31][0:127];
    logic [19:0]           notes [$];
    logic [31:0]           lfsr;
    int                    n_mismatch;
    int                    tests_run;
    int                    n_pulse;

    chl_sequencer i_dut (.clk(clk), .reset(reset), .kb_home(kb_home), .kb_req(kb_req), .host_req(host_req),
        .host_column_zero_strobe(hcs), .host_row_zero_strobe(hrs), .mem_read_data(rd), .mem_cmd(mem_cmd),
        .refresh_skip(refresh_skip), .busy(busy), .cursor_count_pulse(ccp), .cursor_column_counter(col),
        .cursor_row_counter(row));

    chl_mem_model i_mem (.clk(clk), .mem_cmd(mem_cmd), .col(col), .row(row), .read_data(rd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr_next

    task automatic cmp_write(input logic [19:0] exp, input logic [19:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t write exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_write

    task automatic cmp_val(input logic [13:0] exp, input logic [13:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t value exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_val

    task automatic final_report;
        $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        #1;
        cmp_val(14'h0000, {busy, refresh_skip, col, row});
    endtask : wait_idle

    // Notes each expected blank write in scan order, then runs one clear.
    task automatic run_clear(input chl_pkg::chl_req_t k, input chl_pkg::chl_req_t h, input logic total);
        for (int r = 0; r < 27; r++) begin
            for (int c = 0; c < 74; c++) begin
                if (total || shadow[r][c][chl_pkg::BRIGHT_BIT]) begin
                    notes.push_back({r[4:0], c[6:0], chl_pkg::BLANK_CHAR});
                    shadow[r][c] = chl_pkg::BLANK_CHAR;
                end
            end
        end
        n_pulse = 0;
        @(posedge clk);
        kb_req <= k;
        host_req <= h;
        @(posedge clk);
        kb_req <= '0;
        host_req <= '0;
        repeat (100) @(posedge clk);
        #1;
        cmp_val(14'h0001, {13'h0000, refresh_skip});
        wait_idle();
        cmp_val(14'h0000, 14'(notes.size()));
        // One count pulse per location: 74 columns by 27 rows.
        cmp_val(14'h07CE, 14'(n_pulse));
    endtask : run_clear

    // Each write must match the oldest note, address and data together.
    always @(posedge clk) begin
        if (!reset && ccp === 1'b1) begin
            n_pulse++;
        end
        if (!reset && mem_cmd.write === 1'b1) begin
            if (notes.size() == 0) begin
                cmp_write(20'hFFFFF, {row, col, mem_cmd.data});
            end else begin
                cmp_write(notes.pop_front(), {row, col, mem_cmd.data});
            end
        end
    end

    initial begin
        #(10 * 95000);
        n_mismatch++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        kb_home = 1'b0;
        kb_req = '0;
        host_req = '0;
        hcs = 1'b0;
        hrs = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        n_pulse = 0;
        lfsr = 32'h3986;
        for (int r = 0; r < 32; r++) begin
            for (int c = 0; c < 128; c++) begin
                lfsr = lfsr_next(lfsr);
                shadow[r][c] = lfsr[7:0];
                i_mem.cells[r][c] = lfsr[7:0];
            end
        end
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        cmp_val(14'h0000, {busy, refresh_skip, col, row});
        $display("test reset done");
        @(posedge clk);
        kb_home <= 1'b1;
        @(posedge clk);
        kb_home <= 1'b0;
        #1;
        cmp_val(14'h0001, {13'h0000, busy});
        wait_idle();
        $display("test keyboard home done");
        run_clear(3'b100, 3'b000, 1'b0);
        $display("test bright-only clear done");
        run_clear(3'b100, 3'b010, 1'b1);
        $display("test total clear done");
        @(posedge clk);
        hcs <= 1'b1;
        hrs <= 1'b1;
        @(posedge clk);
        hcs <= 1'b0;
        hrs <= 1'b0;
        @(posedge clk);
        #1;
        cmp_val(14'h0000, {busy, refresh_skip, col, row});
        // The first insert write copies row 30 into row 31 at the last column.
        notes.push_back({chl_pkg::ROW_FULL, chl_pkg::COL_FULL, shadow[30][127]});
        @(posedge clk);
        host_req <= 3'b001;
        @(posedge clk);
        host_req <= '0;
        repeat (45) @(posedge clk);
        #1;
        cmp_val(14'h0001, {13'h0000, refresh_skip});
        cmp_val(14'h0000, 14'(notes.size()));
        @(posedge clk);
        hcs <= 1'b1;
        hrs <= 1'b1;
        @(posedge clk);
        hcs <= 1'b0;
        hrs <= 1'b0;
        #1;
        cmp_val(14'h3000, {busy, refresh_skip, col, row});
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        cmp_val(14'h0000, {busy, refresh_skip, mem_cmd.read, mem_cmd.write, 10'h000});
        $display("test insert with reset done");
        final_report();
    end
endmodule : tb_cursor_home_clear_insert_line_sequencer
`default_nettype wire
